// File: aol_pkg.sv
// constants shared by the black-level loop and output-stage control
// assumes one 25 MHz sample clock and a zero-wait-free apb master
//
// Notes on behaviour
// - black window drives offset correction each line
// - one line is one black pulse period
// - correction is error times 0.078/(fclk*c3)
// - gain change enters lead-in with multiplied gain
// - gain select maps to 4, 8, 16, 32
// - error above 16 lsb keeps lead-in
// - small error leaves lead-in after 1-8 lines
// - preblank outside test mode isolates input, output shows clamp
// - standby, output enable, test pattern control output
// - msb and low-bit inversion of output
// - binary or gray coding, inversion applied after
// - test pattern beats preblank; else preblank beats inversion, forces clamp level
// - binary code is step n directly
// - gray code is n xor n shifted right
// - output controls live in config bits
// - window is cycles 5-12, eight samples averaged
// - latency ten sampled, nine direct input
// - clamp is 14 plus 2 lsb per step
package aol_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_LOOP = 8'h04;
  localparam logic [7:0] ADDR_GAIN = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam logic [7:0] ADDR_DAC = 8'h10;
  localparam int CTRL_STANDBY_CTL = 0;
  localparam int CTRL_OE = 1;
  localparam int CTRL_TEST = 2;
  localparam int CTRL_GRAY = 3;
  localparam int CTRL_LOW_BITS_INVERT = 4;
  localparam int CTRL_MSB_INVERT = 5;
  localparam int CTRL_DIRECT = 6;
  localparam int LOOP_CLAMP_LSB = 0;
  localparam int LOOP_NSEL_LSB = 8;
  localparam int LOOP_HSEL_LSB = 10;
  localparam int STAT_ERR_LSB = 16;
  localparam int STAT_LEADIN = 31;
  // ==========================================================
  // loop constants
  localparam int FCLK_MHZ = 25;
  localparam int C3_NF = 1000;
  localparam int LOOP_NUM_MILLI = 78;
  localparam int COEF_FRAC = 16;
  localparam logic [8:0] LOOP_COEF =
    9'((LOOP_NUM_MILLI * (1 << COEF_FRAC)) / (1000 * FCLK_MHZ * C3_NF / 1000));
  localparam logic [2:0] LEADIN_SHIFT_BASE = 3'h2;
  localparam logic [10:0] ERR_LIMIT = 11'h010;
  localparam logic [3:0] WIN_FIRST = 4'h5;
  localparam logic [3:0] WIN_LAST = 4'hC;
  localparam int AVG_SHIFT = 3;
  localparam logic [9:0] CLAMP_BASE = 10'h00E;
  localparam int CLAMP_STEP_SHIFT = 1;
  // ==========================================================
  // output stage constants
  localparam int LAT_SAMPLED = 10;
  localparam int LAT_DIRECT = 9;
  localparam int PIPE_DEPTH = LAT_SAMPLED - 1;
  localparam logic [9:0] TEST_PATTERN = 10'h2AA;
  localparam logic [4:0] CLAMP_RST = 5'h00;
endpackage : aol_pkg

// File: aol_sync2.sv
// two-flop synchroniser for one pin level
// assumes the pin is asynchronous to clk
`timescale 1ns/1ps
module aol_sync2 (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic d,
  output logic q
);
  logic meta_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= 1'b0;
      q <= 1'b0;
    end else if (ce) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : aol_sync2

// File: aol_out_coder.sv
// combinational output code selection for the ten data bits
// assumes caller registers the result
`timescale 1ns/1ps
module aol_out_coder (
  input wire logic [9:0] sample,
  input wire logic [9:0] clampLevel,
  input wire logic testSel,
  input wire logic graySel,
  input wire logic lowInv,
  input wire logic msbInv,
  input wire logic preblank,
  output logic [9:0] code
);
  logic [9:0] src;
  logic [9:0] enc;
  logic [9:0] invMask;

  always_comb begin
    src = preblank ? clampLevel : sample;
    enc = graySel ? (src ^ (src >> 1)) : src;
    invMask = {msbInv, {9{lowInv}}};
    if (testSel) begin
      // preblank is ignored in test mode
      code = aol_pkg::TEST_PATTERN ^ invMask;
    end else if (preblank) begin
      code = enc;
    end else begin
      code = enc ^ invMask;
    end
  end
endmodule : aol_out_coder

// File: aol_offset_out_ctl.sv
// black-level offset loop control and adc output stage, apb slave
// assumes adcData is on clk; pins pass through two-flop synchronisers
`timescale 1ns/1ps
module aol_offset_out_ctl (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [9:0] adcData,
  input wire logic blackWindowPulse,
  input wire logic preblankIn,
  output logic [9:0] outWord,
  output logic outWordOe,
  output logic lowPowerWait,
  output logic sampleIsolate,
  output logic [9:0] dacCode,
  output logic leadinActive
);
  // ==========================================================
  // state
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic standby;
    logic outEn;
    logic testSel;
    logic graySel;
    logic lowInv;
    logic msbInv;
    logic directMode;
    logic [4:0] clampCode;
    logic [1:0] gainSel;
    logic [1:0] cancelSel;
    logic [7:0] secondGain;
    logic pulseDly;
    logic winActive;
    logic [3:0] winCnt;
    logic [12:0] winSum;
    logic [9:0] blackAvg;
    logic signed [10:0] offErr;
    logic leadin;
    logic [3:0] cancelCnt;
    logic signed [27:0] dacAcc;
    logic [aol_pkg::PIPE_DEPTH-1:0][9:0] pipe;
    logic [9:0] outWord;
    logic outOe;
    logic lowPower;
    logic isolate;
  } aol_state_t;

  aol_state_t st_reg;
  aol_state_t st_next;

  logic pulseSync;
  logic pblkSync;
  logic pulseEdge;
  logic lineDone;
  logic inWindow;
  logic [12:0] sumNow;
  logic [9:0] avgNow;
  logic [9:0] clampLevel;
  logic signed [10:0] errNow;
  logic [10:0] errMag;
  logic signed [20:0] errProd;
  logic signed [27:0] stepVal;
  logic [2:0] gainShift;
  logic [3:0] cancelLines;
  logic [3:0] cancelInc;
  logic [9:0] tapSample;
  logic [9:0] codeNext;
  logic apbAccess;
  logic gainChange;

  aol_sync2 u_sync_pulse (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .d(blackWindowPulse),
    .q(pulseSync)
  );

  aol_sync2 u_sync_preblank_in (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .d(preblankIn),
    .q(pblkSync)
  );

  aol_out_coder u_coder (
    .sample(tapSample),
    .clampLevel(clampLevel),
    .testSel(st_reg.testSel),
    .graySel(st_reg.graySel),
    .lowInv(st_reg.lowInv),
    .msbInv(st_reg.msbInv),
    .preblank(pblkSync),
    .code(codeNext)
  );

  // ==========================================================
  // datapath terms
  always_comb begin
    clampLevel = aol_pkg::CLAMP_BASE
      + 10'({st_reg.clampCode, 1'b0});
    pulseEdge = pulseSync && !st_reg.pulseDly;
    inWindow = st_reg.winActive && (st_reg.winCnt >= aol_pkg::WIN_FIRST)
      && (st_reg.winCnt <= aol_pkg::WIN_LAST);
    lineDone = st_reg.winActive && (st_reg.winCnt == aol_pkg::WIN_LAST);
    sumNow = st_reg.winSum + {3'h0, adcData};
    avgNow = sumNow[aol_pkg::AVG_SHIFT +: 10];
    errNow = $signed({1'b0, avgNow}) - $signed({1'b0, clampLevel});
    errMag = errNow[10] ? 11'(-errNow) : errNow;
    // coefficient folds 0.078/(fclk*c3) into a q16 multiplier
    errProd = errNow * $signed({1'b0, aol_pkg::LOOP_COEF});
    gainShift = st_reg.leadin
      ? aol_pkg::LEADIN_SHIFT_BASE + {1'b0, st_reg.gainSel} : 3'h0;
    stepVal = 28'(errProd) <<< gainShift;
    cancelLines = 4'h1 << st_reg.cancelSel;
    cancelInc = st_reg.cancelCnt + 4'h1;
    tapSample = st_reg.directMode
      ? st_reg.pipe[aol_pkg::LAT_DIRECT-2]
      : st_reg.pipe[aol_pkg::LAT_SAMPLED-2];
    apbAccess = psel && penable && st_reg.pready;
    gainChange = apbAccess && pwrite && (paddr == aol_pkg::ADDR_GAIN)
      && (pwdata[7:0] != st_reg.secondGain);
  end

  // ==========================================================
  // next state
  always_comb begin
    st_next = st_reg;
    // apb: one wait state, answer registered
    st_next.pready = psel && penable && !st_reg.pready;
    st_next.pslverr = 1'b0;
    st_next.prdata = 32'h0000_0000;
    if (psel && penable && !st_reg.pready) begin
      case (paddr)
        aol_pkg::ADDR_CTRL: begin
          st_next.prdata[aol_pkg::CTRL_STANDBY_CTL] = st_reg.standby;
          st_next.prdata[aol_pkg::CTRL_OE] = st_reg.outEn;
          st_next.prdata[aol_pkg::CTRL_TEST] = st_reg.testSel;
          st_next.prdata[aol_pkg::CTRL_GRAY] = st_reg.graySel;
          st_next.prdata[aol_pkg::CTRL_LOW_BITS_INVERT] = st_reg.lowInv;
          st_next.prdata[aol_pkg::CTRL_MSB_INVERT] = st_reg.msbInv;
          st_next.prdata[aol_pkg::CTRL_DIRECT] = st_reg.directMode;
        end
        aol_pkg::ADDR_LOOP: begin
          st_next.prdata[aol_pkg::LOOP_CLAMP_LSB +: 5] = st_reg.clampCode;
          st_next.prdata[aol_pkg::LOOP_NSEL_LSB +: 2] = st_reg.gainSel;
          st_next.prdata[aol_pkg::LOOP_HSEL_LSB +: 2] = st_reg.cancelSel;
        end
        aol_pkg::ADDR_GAIN: st_next.prdata[7:0] = st_reg.secondGain;
        aol_pkg::ADDR_STAT: begin
          st_next.prdata[9:0] = st_reg.blackAvg;
          st_next.prdata[aol_pkg::STAT_ERR_LSB +: 11] = st_reg.offErr;
          st_next.prdata[aol_pkg::STAT_LEADIN] = st_reg.leadin;
        end
        aol_pkg::ADDR_DAC: st_next.prdata[9:0] = st_reg.dacAcc[25:16];
        default: st_next.pslverr = 1'b1;
      endcase
    end
    if (apbAccess && pwrite) begin
      case (paddr)
        aol_pkg::ADDR_CTRL: begin
          st_next.standby = pwdata[aol_pkg::CTRL_STANDBY_CTL];
          st_next.outEn = pwdata[aol_pkg::CTRL_OE];
          st_next.testSel = pwdata[aol_pkg::CTRL_TEST];
          st_next.graySel = pwdata[aol_pkg::CTRL_GRAY];
          st_next.lowInv = pwdata[aol_pkg::CTRL_LOW_BITS_INVERT];
          st_next.msbInv = pwdata[aol_pkg::CTRL_MSB_INVERT];
          st_next.directMode = pwdata[aol_pkg::CTRL_DIRECT];
        end
        aol_pkg::ADDR_LOOP: begin
          st_next.clampCode = pwdata[aol_pkg::LOOP_CLAMP_LSB +: 5];
          st_next.gainSel = pwdata[aol_pkg::LOOP_NSEL_LSB +: 2];
          st_next.cancelSel = pwdata[aol_pkg::LOOP_HSEL_LSB +: 2];
        end
        aol_pkg::ADDR_GAIN: st_next.secondGain = pwdata[7:0];
        default: begin
        end
      endcase
    end
    // black window: counter restarts on each pulse edge
    st_next.pulseDly = pulseSync;
    if (pulseEdge) begin
      st_next.winActive = 1'b1;
      st_next.winCnt = 4'h1;
      st_next.winSum = 13'h0000;
    end else if (st_reg.winActive) begin
      st_next.winCnt = st_reg.winCnt + 4'h1;
      if (inWindow) begin
        st_next.winSum = sumNow;
      end
      if (lineDone) begin
        st_next.winActive = 1'b0;
        st_next.blackAvg = avgNow;
        st_next.offErr = errNow;
        // negative feedback: raise black level when below clamp
        st_next.dacAcc = st_reg.dacAcc - stepVal;
        if (st_reg.leadin) begin
          if (errMag > aol_pkg::ERR_LIMIT) begin
            st_next.cancelCnt = 4'h0;
          end else if (cancelInc >= cancelLines) begin
            st_next.leadin = 1'b0;
            st_next.cancelCnt = 4'h0;
          end else begin
            st_next.cancelCnt = cancelInc;
          end
        end
      end
    end
    // a gain change wins over a lead-in exit in the same cycle
    if (gainChange) begin
      st_next.leadin = 1'b1;
      st_next.cancelCnt = 4'h0;
    end
    // output stage
    st_next.pipe[0] = adcData;
    for (int i = 1; i < aol_pkg::PIPE_DEPTH; i++) begin
      st_next.pipe[i] = st_reg.pipe[i-1];
    end
    st_next.outWord = codeNext;
    st_next.outOe = !st_reg.standby && st_reg.outEn;
    st_next.lowPower = st_reg.standby;
    st_next.isolate = pblkSync && !st_reg.testSel;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  always_comb begin
    prdata = st_reg.prdata;
    pready = st_reg.pready;
    pslverr = st_reg.pslverr;
    outWord = st_reg.outWord;
    outWordOe = st_reg.outOe;
    lowPowerWait = st_reg.lowPower;
    sampleIsolate = st_reg.isolate;
    dacCode = st_reg.dacAcc[25:16];
    leadinActive = st_reg.leadin;
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !ce);

  sequence sWindow;
    pulseEdge ##12 lineDone;
  endsequence

  sequence sPlainOut;
    !st_reg.testSel && !pblkSync && !st_reg.lowInv && !st_reg.msbInv
      && !st_reg.directMode;
  endsequence

  a_window_span: assert property (pulseEdge |-> sWindow)
    else $error("window end not twelve cycles after pulse");
  a_standby_hiz: assert property (st_reg.standby |=> !outWordOe)
    else $error("outputs driven in standby");
  a_apb_ready: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
  a_leadin_enter: assert property (gainChange |=> leadinActive)
    else $error("gain change did not enter lead-in");
  a_leadin_hold: assert property (lineDone && st_reg.leadin
    && errMag > aol_pkg::ERR_LIMIT |=> leadinActive)
    else $error("lead-in left with large error");
  a_dac_step: assert property (lineDone && !st_reg.leadin |=>
    st_reg.dacAcc == $past(st_reg.dacAcc) - 28'($past(errProd)))
    else $error("normal loop step wrong");
  a_bin_latency: assert property (sPlainOut and !st_reg.graySel |=>
    outWord == $past(adcData, 10))
    else $error("binary output latency wrong");
  a_gray_code: assert property (sPlainOut and st_reg.graySel |=>
    outWord == ($past(adcData, 10) ^ ($past(adcData, 10) >> 1)))
    else $error("gray output wrong");
  a_preblank_in_clamp: assert property (pblkSync && !st_reg.testSel
    && !st_reg.graySel |=> outWord == $past(clampLevel))
    else $error("preblank did not force clamp");
  a_msb_invert: assert property (!st_reg.testSel && !pblkSync
    && st_reg.msbInv && !st_reg.lowInv && !st_reg.graySel
    && !st_reg.directMode |=> outWord == ($past(adcData, 10) ^ 10'h200))
    else $error("msb inversion wrong");
endmodule : aol_offset_out_ctl

// File: aol_dsp_model.sv
// downstream dsp model: captures the output word while it is driven
// assumes outWord and outWordOe come from the block on clk
`timescale 1ns/1ps
module aol_dsp_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [9:0] outWord,
  input wire logic outWordOe,
  output logic [9:0] capWord,
  output logic capValid
);
  // ==========================================================
  // capture
  // undriven pins float: keep inverting, so the held word equals the stale word only on every second cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      capWord <= 10'h000;
      capValid <= 1'b0;
    end else if (outWordOe) begin
      capWord <= outWord;
      capValid <= 1'b1;
    end else begin
      capWord <= ~capWord;
      capValid <= 1'b0;
    end
  end
endmodule : aol_dsp_model

// File: tb_top.sv
// testbench for the offset loop and output stage, driven over apb
// assumes the apb slave answers with one wait state, no sync on adcData
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [9:0] adcData = 10'h000;
  logic blackWindowPulse = 1'b0;
  logic preblankIn = 1'b0;
  logic [9:0] outWord;
  logic [9:0] dacCode;
  logic [9:0] capWord;
  logic outWordOe;
  logic lowPowerWait;
  logic sampleIsolate;
  logic leadinActive;
  logic capValid;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;
  logic [31:0] rd;
  logic er;
  logic signed [31:0] acc;

  always #20 clk = ~clk;

  aol_offset_out_ctl uut (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adcData(adcData), .blackWindowPulse(blackWindowPulse),
    .preblankIn(preblankIn), .outWord(outWord), .outWordOe(outWordOe),
    .lowPowerWait(lowPowerWait), .sampleIsolate(sampleIsolate),
    .dacCode(dacCode), .leadinActive(leadinActive));

  aol_dsp_model dsp (.clk(clk), .rst(rst), .outWord(outWord),
    .outWordOe(outWordOe), .capWord(capWord), .capValid(capValid));

  // ==========================================================
  // helpers
  task close_out;
    if (err_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 40);
    if (k >= 40) err_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task settle(input int c);
    repeat (c) @(negedge clk);
  endtask : settle

  function logic [9:0] code(logic [9:0] v, logic g, logic l, logic m);
    code = (g ? v ^ (v >> 1) : v) ^ {m, {9{l}}};
  endfunction : code

  function logic [31:0] ctl(logic s, logic o, logic t, logic g,
                            logic l, logic m, logic dm);
    ctl = {25'h0, dm, m, l, g, t, o, s};
  endfunction : ctl

  // one line: constant level across the whole black window
  task line(input logic [9:0] v);
    @(posedge clk);
    adcData <= v;
    blackWindowPulse <= 1'b1;
    repeat (3) @(posedge clk);
    blackWindowPulse <= 1'b0;
    settle(25);
  endtask : line

  // hang guard, far above the several hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      close_out();
    end
  end

  // ==========================================================
  // sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, aol_pkg::ADDR_CTRL, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, aol_pkg::ADDR_LOOP, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    check(er, 32'h1);
    check(rd, 32'h0);
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, aol_pkg::ADDR_CTRL, ctl(0, 1, 0, i[2], i[1], i[0], 0));
      adcData <= i[3] ? 10'h2C5 : 10'h200;
      settle(14);
      check(capWord, code(i[3] ? 10'h2C5 : 10'h200, i[2], i[1], i[0]));
    end
    for (int dm = 0; dm < 2; dm++) begin
      apb(1'b1, aol_pkg::ADDR_CTRL, ctl(0, 1, 0, 0, 0, 0, dm[0]));
      adcData <= 10'h000;
      settle(14);
      @(posedge clk);
      adcData <= 10'h155;
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (outWord !== 10'h155 && n < 30);
      check(n, (dm ? aol_pkg::LAT_DIRECT : aol_pkg::LAT_SAMPLED) + 1);
    end
    // clamp code 5 gives 14 + 2 * 5 = 24
    apb(1'b1, aol_pkg::ADDR_LOOP, 32'h5);
    preblankIn <= 1'b1;
    for (int g = 0; g < 2; g++) begin
      apb(1'b1, aol_pkg::ADDR_CTRL, ctl(0, 1, 0, g[0], 1, 1, 0));
      settle(14);
      check(capWord, code(10'h018, g[0], 0, 0));
      check(sampleIsolate, 32'h1);
    end
    for (int j = 0; j < 4; j++) begin
      apb(1'b1, aol_pkg::ADDR_CTRL, ctl(0, 1, 1, 0, j[1], j[0], 0));
      settle(14);
      check(capWord, aol_pkg::TEST_PATTERN ^ {j[0], {9{j[1]}}});
      check(sampleIsolate, 32'h0);
    end
    apb(1'b1, aol_pkg::ADDR_CTRL, ctl(1, 1, 0, 0, 0, 0, 0));
    preblankIn <= 1'b0;
    settle(3);
    check(outWordOe, 32'h0);
    check(lowPowerWait, 32'h1);
    check(capValid, 32'h0);
    apb(1'b1, aol_pkg::ADDR_CTRL, ctl(0, 0, 0, 0, 0, 0, 0));
    settle(3);
    check(outWordOe, 32'h0);
    check(lowPowerWait, 32'h0);
    // cancel after 2 lines, gain times 16; loop gain stays far below one
    apb(1'b1, aol_pkg::ADDR_LOOP, {20'h0, 2'h1, 2'h2, 3'h0, 5'h05});
    apb(1'b1, aol_pkg::ADDR_GAIN, 32'h10);
    settle(2);
    check(leadinActive, 32'h1);
    line(10'h029);
    check(leadinActive, 32'h1);
    apb(1'b0, aol_pkg::ADDR_STAT, 32'h0);
    check(rd[26:16], 11'h011);
    check(rd[9:0], 10'h029);
    acc = -(32'sd17 * 32'sd204 * 32'sd16);
    check(dacCode, acc[25:16]);
    line(10'h028);
    check(leadinActive, 32'h1);
    // both small-error lines still step with the lead-in gain
    acc = acc - 32'sd16 * 32'sd204 * 32'sd16;
    check(dacCode, acc[25:16]);
    line(10'h028);
    check(leadinActive, 32'h0);
    acc = acc - 32'sd16 * 32'sd204 * 32'sd16;
    line(10'h029);
    acc = acc - 32'sd17 * 32'sd204;
    check(dacCode, acc[25:16]);
    apb(1'b0, aol_pkg::ADDR_DAC, 32'h0);
    check(rd[9:0], acc[25:16]);
    close_out();
  end
endmodule : tb_top
